/* File: param_table_pkg.sv */
// shared constants, table contents and state types for the parameter table reader
package param_table_pkg;

    // ------------------------------------------------------------
    // serial frame layout
    // ------------------------------------------------------------
    localparam int          CMD_BITS      = 8;
    localparam int          ADDR_BITS     = 24;
    localparam int          TBL_AW        = 8;
    localparam int          UID_BYTES     = 8;
    localparam logic [7:0]  RD_TABLE_CMD  = 8'h5A;
    localparam logic [4:0]  CNT_RST       = 5'h00;
    localparam logic [7:0]  BYTE_RST      = 8'h00;
    localparam logic [7:0]  BLANK_BYTE    = 8'hFF;

    // ------------------------------------------------------------
    // table byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  A_FEATURES    = 8'h80;
    localparam logic [7:0]  A_ERASE_OP    = 8'h81;
    localparam logic [7:0]  A_READ_SUP    = 8'h82;
    localparam logic [7:0]  A_DENSITY     = 8'h87;
    localparam logic [7:0]  A_QIO_CFG     = 8'h88;
    localparam logic [7:0]  A_QIO_OP      = 8'h89;
    localparam logic [7:0]  A_QOUT_CFG    = 8'h8A;
    localparam logic [7:0]  A_QOUT_OP     = 8'h8B;
    localparam logic [7:0]  A_DOUT_CFG    = 8'h8C;
    localparam logic [7:0]  A_DOUT_OP     = 8'h8D;
    localparam logic [7:0]  A_DIO_CFG     = 8'h8E;
    localparam logic [7:0]  A_DIO_OP      = 8'h8F;
    localparam logic [7:0]  A_UNIFORM_SUP = 8'h90;
    localparam logic [7:0]  A_SECT1_SIZE  = 8'h9C;
    localparam logic [7:0]  A_SECT1_OP    = 8'h9D;
    localparam logic [7:0]  A_SECT2_SIZE  = 8'h9E;
    localparam logic [7:0]  A_SECT2_OP    = 8'h9F;
    localparam logic [7:0]  A_SECT3_SIZE  = 8'hA0;
    localparam logic [7:0]  A_SECT3_OP    = 8'hA1;
    localparam logic [7:0]  A_SECT4_SIZE  = 8'hA2;
    localparam logic [7:0]  A_SECT4_OP    = 8'hA3;
    localparam logic [7:0]  A_UID_BASE    = 8'hF8;

    // ------------------------------------------------------------
    // table byte values
    // ------------------------------------------------------------
    localparam logic [7:0]  V_FEATURES    = 8'hE5;
    localparam logic [7:0]  V_ERASE_OP    = 8'h20;
    localparam logic [7:0]  V_READ_SUP    = 8'hF1;
    localparam logic [7:0]  V_QIO_CFG     = 8'h44;
    localparam logic [7:0]  V_QIO_OP      = 8'hEB;
    localparam logic [7:0]  V_QOUT_CFG    = 8'h08;
    localparam logic [7:0]  V_QOUT_OP     = 8'h6B;
    localparam logic [7:0]  V_DOUT_CFG    = 8'h08;
    localparam logic [7:0]  V_DOUT_OP     = 8'h3B;
    localparam logic [7:0]  V_DIO_CFG     = 8'h80;
    localparam logic [7:0]  V_DIO_OP      = 8'hBB;
    localparam logic [7:0]  V_UNIFORM_SUP = 8'hEE;
    localparam logic [7:0]  V_SECT1_SIZE  = 8'h0C;
    localparam logic [7:0]  V_SECT1_OP    = 8'h20;
    localparam logic [7:0]  V_SECT2_SIZE  = 8'h10;
    localparam logic [7:0]  V_SECT2_OP    = 8'hD8;
    localparam logic [7:0]  V_SECT_NONE   = 8'h00;
    localparam logic [7:0]  V_DENSITY     = 8'h00;

    // ------------------------------------------------------------
    // frame states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_CMD,
        ST_ADDR,
        ST_DATA,
        ST_IGNORE
    } frame_e;

endpackage : param_table_pkg

/* File: table_if.sv */
// lookup carrier between the serial front end and the table memory
`timescale 1ns/1ps
interface table_if;
    import param_table_pkg::*;
    logic [TBL_AW-1:0]        addr;
    logic [7:0]               data;
    logic [UID_BYTES*8-1:0]   uid;

    modport reader (output addr, output uid, input data);
    modport store  (input addr, input uid, output data);
endinterface : table_if

/* File: param_table_rom.sv */
// table memory: one byte per address, read data registered
`timescale 1ns/1ps
module param_table_rom
    import param_table_pkg::*;
#(
    parameter logic [7:0] DENSITY_CODE = V_DENSITY
) (
    input  wire logic   ref_clk_in,
    input  wire logic   nrst_in,
    table_if.store      tbl
);

    typedef struct packed {
        logic [7:0] q;
    } rom_s;

    rom_s st_r;
    rom_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        unique case (tbl.addr)
            A_FEATURES:    st_nxt.q = V_FEATURES;                     // see (R10)
            A_ERASE_OP:    st_nxt.q = V_ERASE_OP;
            A_READ_SUP:    st_nxt.q = V_READ_SUP;                     // see (R11)
            A_DENSITY:     st_nxt.q = DENSITY_CODE;
            A_QIO_CFG:     st_nxt.q = V_QIO_CFG;                      // see (R1)
            A_QIO_OP:      st_nxt.q = V_QIO_OP;                       // see (R1)
            A_QOUT_CFG:    st_nxt.q = V_QOUT_CFG;                     // see (R2)
            A_QOUT_OP:     st_nxt.q = V_QOUT_OP;                      // see (R2)
            A_DOUT_CFG:    st_nxt.q = V_DOUT_CFG;                     // see (R3)
            A_DOUT_OP:     st_nxt.q = V_DOUT_OP;                      // see (R3)
            A_DIO_CFG:     st_nxt.q = V_DIO_CFG;                      // see (R4)
            A_DIO_OP:      st_nxt.q = V_DIO_OP;                       // see (R4)
            A_UNIFORM_SUP: st_nxt.q = V_UNIFORM_SUP;                  // see (R5) see (R6)
            A_SECT1_SIZE:  st_nxt.q = V_SECT1_SIZE;                   // see (R7)
            A_SECT1_OP:    st_nxt.q = V_SECT1_OP;                     // see (R7)
            A_SECT2_SIZE:  st_nxt.q = V_SECT2_SIZE;                   // see (R8)
            A_SECT2_OP:    st_nxt.q = V_SECT2_OP;                     // see (R8)
            A_SECT3_SIZE,
            A_SECT4_SIZE:  st_nxt.q = V_SECT_NONE;                    // see (R9)
            default: begin
                // uid occupies the top eight bytes, first byte is the lowest
                if (tbl.addr >= A_UID_BASE) begin
                    st_nxt.q = tbl.uid[{tbl.addr[2:0], 3'b000} +: 8];  // see (R12)
                end else begin
                    // reserved, absent sector opcodes and unsupported protocol bytes
                    st_nxt.q = BLANK_BYTE;                             // see (R5) see (R6) see (R9) see (R12)
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r.q <= BLANK_BYTE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tbl.data = st_r.q;

endmodule : param_table_rom

/* File: param_table_reader.sv */
// serial front end returning the discoverable parameter table
`timescale 1ns/1ps

// Behaviour
// (R1) quad io read: opcode EBh, byte 88h reads 44h (2 mode, 4 dummy).
// (R2) quad output read: opcode 6Bh, byte 8Ah reads 08h (8 dummy).
// (R3) dual output read: opcode 3Bh, byte 8Ch reads 08h (8 dummy).
// (R4) dual io read: opcode BBh, byte 8Eh reads 80h (4 mode, 0 dummy).
// (R5) support dword bit 4 zero: 4-4-4 read absent, its bytes read FFh.
// (R6) support dword bit 0 zero: 2-2-2 read absent, byte 97h reads FFh.
// (R7) sector type 1: size 0Ch at 9Ch, opcode 20h at 9Dh.
// (R8) sector type 2: size 10h at 9Eh, opcode D8h at 9Fh.
// (R9) sector types 3 and 4 absent: sizes 00h, opcodes FFh.
// (R10) byte 80h reads E5h.
// (R11) byte 82h reads F1h.
// (R12) reserved bytes and A4h..F7h read FFh; F8h..FFh hold unique id.
// (R13) read command plus address, then bytes stream with incrementing address.
module param_table_reader
    import param_table_pkg::*;
#(
    parameter int         ADDR_W       = ADDR_BITS,
    parameter logic [7:0] READ_CMD     = RD_TABLE_CMD,
    parameter logic [7:0] DENSITY_CODE = V_DENSITY
) (
    input  wire logic                    ref_clk_in,
    input  wire logic                    nrst_in,
    input  wire logic                    sck_in,
    input  wire logic                    cs_n_in,
    input  wire logic                    mosi_in,
    input  wire logic [UID_BYTES*8-1:0]  uid_in,
    output logic                         miso_out,
    output logic                         miso_oe_n_out
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (ADDR_W < TBL_AW || ADDR_W > 32) begin : g_bad_addr
        $error("address width must lie between table width and 32");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        frame_e             fsm;
        logic               sck_d;
        logic [4:0]         cnt;
        logic [ADDR_W-1:0]  shin;
        logic [TBL_AW-1:0]  ptr;
        logic [7:0]         shout;
        logic               miso;
    } reader_s;

    reader_s st_r;
    reader_s st_nxt;

    table_if tbl ();

    logic sck_rise;
    logic sck_fall;

    assign sck_rise = sck_in & ~st_r.sck_d;
    assign sck_fall = ~sck_in & st_r.sck_d;

    // ------------------------------------------------------------
    // frame sequencing
    // ------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        st_nxt.sck_d = sck_in;
        if (cs_n_in) begin
            // chip select high ends the frame wherever it stood
            st_nxt.fsm  = ST_CMD;                                     // see (R13)
            st_nxt.cnt  = CNT_RST;
            st_nxt.miso = 1'b1;
        end else begin
            unique case (st_r.fsm)
                ST_CMD: begin
                    if (sck_rise) begin
                        st_nxt.shin = {st_r.shin[ADDR_W-2:0], mosi_in};
                        st_nxt.cnt  = st_r.cnt + 5'd1;
                        if (st_r.cnt == 5'(CMD_BITS - 1)) begin
                            st_nxt.cnt = CNT_RST;
                            // any other opcode is left to other logic
                            st_nxt.fsm = ({st_r.shin[6:0], mosi_in} == READ_CMD)
                                         ? ST_ADDR : ST_IGNORE;  // see (R13)
                        end
                    end
                end
                ST_ADDR: begin
                    if (sck_rise) begin
                        st_nxt.shin = {st_r.shin[ADDR_W-2:0], mosi_in};
                        st_nxt.cnt  = st_r.cnt + 5'd1;
                        if (st_r.cnt == 5'(ADDR_W - 1)) begin
                            // only the low bits select a table byte; the table wraps
                            st_nxt.ptr = {st_r.shin[TBL_AW-2:0], mosi_in};  // see (R13)
                            st_nxt.cnt = CNT_RST;
                            st_nxt.fsm = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (sck_rise) begin
                        st_nxt.cnt = {2'b00, st_r.cnt[2:0] + 3'd1};
                    end
                    if (sck_fall) begin
                        if (st_r.cnt[2:0] == 3'd0) begin
                            // memory output already reflects ptr, one clock old
                            st_nxt.shout = tbl.data;
                            st_nxt.miso  = tbl.data[7];
                            st_nxt.ptr   = st_r.ptr + 8'd1;           // see (R13)
                        end else begin
                            st_nxt.shout = {st_r.shout[6:0], 1'b1};
                            st_nxt.miso  = st_r.shout[6];
                        end
                    end
                end
                ST_IGNORE: begin
                    st_nxt.miso = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_r.fsm   <= ST_CMD;
            st_r.sck_d <= 1'b0;
            st_r.cnt   <= CNT_RST;
            st_r.shin  <= '0;
            st_r.ptr   <= BYTE_RST;
            st_r.shout <= BLANK_BYTE;
            st_r.miso  <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // table memory and pin drive
    // ------------------------------------------------------------
    assign tbl.addr = st_r.ptr;
    assign tbl.uid  = uid_in;

    param_table_rom #(
        .DENSITY_CODE (DENSITY_CODE)
    ) u_rom (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .tbl        (tbl.store)
    );

    assign miso_out      = st_r.miso;
    assign miso_oe_n_out = ~((st_r.fsm == ST_DATA) & ~cs_n_in);  // see (R13)

endmodule : param_table_reader

/* File: table_reader_monitor.sv */
// concurrent checks on the parameter table reader ports
`timescale 1ns/1ps
module table_reader_monitor
    import param_table_pkg::*;
#(
    parameter logic [7:0] READ_CMD = RD_TABLE_CMD
) (
    input wire logic                   ref_clk_in,
    input wire logic                   nrst_in,
    input wire logic                   sck_in,
    input wire logic                   cs_n_in,
    input wire logic                   mosi_in,
    input wire logic [UID_BYTES*8-1:0] uid_in,
    input wire logic                   miso_out,
    input wire logic                   miso_oe_n_out
);
    logic        sck_r;
    logic [11:0] nrise_r;
    logic [7:0]  cmd_r;
    logic [7:0]  addr_r;
    logic        rise;
    logic        fall;
    logic        hit;
    logic [7:0]  ptr;
    logic [5:0]  uidx;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    assign rise = sck_in & ~sck_r & ~cs_n_in;
    assign fall = ~sck_in & sck_r & ~cs_n_in;
    assign hit  = (cmd_r == READ_CMD) && (nrise_r >= 12'h020);
    // byte being shifted out: start address plus whole data bytes seen
    assign ptr  = addr_r + nrise_r[10:3] - 8'h04;
    assign uidx = {ptr[2:0], ~nrise_r[2:0]};
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sck_r   <= 1'b0;
            nrise_r <= 12'h000;
            cmd_r   <= 8'h00;
            addr_r  <= 8'h00;
        end else begin
            sck_r <= sck_in;
            if (cs_n_in) begin
                nrise_r <= 12'h000;
            end else if (rise) begin
                nrise_r <= nrise_r + 12'h001;
                if (nrise_r < 12'h008) cmd_r <= {cmd_r[6:0], mosi_in};
                if (nrise_r >= 12'h018 && nrise_r < 12'h020) addr_r <= {addr_r[6:0], mosi_in};
            end
        end
    end
    chk_oe_cs_high: assert property (
        cs_n_in |-> miso_oe_n_out) else $error("output enabled while deselected");
    chk_oe_in_header: assert property (
        !cs_n_in && nrise_r < 12'h020 |-> miso_oe_n_out) else $error("early drive");
    chk_oe_on_match: assert property (
        rise && nrise_r == 12'h01F && cmd_r == READ_CMD ##1 !cs_n_in |-> !miso_oe_n_out)
        else $error("no drive after address");
    chk_oe_refused: assert property (
        !cs_n_in && nrise_r >= 12'h008 && cmd_r != READ_CMD |-> miso_oe_n_out)
        else $error("drive on foreign opcode");
    chk_idle_after: assert property (
        $rose(cs_n_in) |-> ##2 miso_out) else $error("data line not idle");
    chk_miso_hold: assert property (
        !miso_oe_n_out && $past(!miso_oe_n_out) && !$past(fall) && !$past(fall, 2)
        |-> $stable(miso_out)) else $error("bit changed between falls");
    chk_uid_bits: assert property (
        fall && hit && ptr >= 8'hF8 |-> ##2 (cs_n_in || miso_out == uid_in[uidx]))
        else $error("unique id bit wrong");
    chk_blank_bits: assert property (
        fall && hit && (ptr < 8'h80 || (ptr >= 8'hA4 && ptr < 8'hF8))
        |-> ##2 (cs_n_in || miso_out)) else $error("blank byte not all ones");
endmodule : table_reader_monitor
bind param_table_reader table_reader_monitor #(.READ_CMD(READ_CMD)) mon (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sck_in(sck_in), .cs_n_in(cs_n_in),
    .mosi_in(mosi_in), .uid_in(uid_in), .miso_out(miso_out), .miso_oe_n_out(miso_oe_n_out));

/* File: spi_host_model.sv */
// host model: mode 0 frames, msb first, gathers returned bytes
`timescale 1ns/1ps
module spi_host_model (
    input  wire logic ref_clk_in,
    input  wire logic miso_in,
    output logic      sck_out,
    output logic      cs_n_out,
    output logic      mosi_out
);
    int         half_cyc = 4;
    logic [7:0] rx_q[$];
    logic [7:0] acc;
    initial begin
        sck_out  = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // clock stands low outside frames; mosi toggles once the header is sent
    task automatic frame(input logic [7:0] cmd, input logic [23:0] a, input int nbits);
        logic [31:0] hdr;
        hdr = {cmd, a};
        rx_q = {};
        @(negedge ref_clk_in);
        cs_n_out = 1'b0;
        for (int i = 0; i < 32 + nbits; i++) begin
            mosi_out = (i < 32) ? hdr[31-i] : ~mosi_out;
            repeat (half_cyc) @(negedge ref_clk_in);
            sck_out = 1'b1;
            acc = {acc[6:0], miso_in};
            if (i >= 32 && (i - 31) % 8 == 0) rx_q.push_back(acc);
            repeat (half_cyc) @(negedge ref_clk_in);
            sck_out = 1'b0;
        end
        repeat (half_cyc) @(negedge ref_clk_in);
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
        repeat (half_cyc) @(negedge ref_clk_in);
    endtask : frame
endmodule : spi_host_model

/* File: serial_flash_parameter_table_bench.sv */
// self-checking bench for the parameter table reader
`timescale 1ns/1ps
module serial_flash_parameter_table_bench;
    import param_table_pkg::*;
    localparam logic [287:0] ROW = {
        64'hE520_F1FF_FFFF_FF00,
        64'h44EB_086B_083B_80BB,
        64'hEEFF_FFFF_FFFF_FFFF,
        64'hFFFF_FFFF_0C20_10D8,
        32'h00FF_00FF};
    logic        ref_clk_in = 1'b0;
    logic        nrst_in = 1'b0;
    logic [63:0] uid = 64'h0;
    logic        miso, oe_n, sck, cs_n, mosi, miso_w;
    int          oe_cnt = 0;
    int          oe_base = 0;
    logic [31:0] r;
    logic [7:0]  tbl[256];
    int          exp_q[$];
    int          num_errors = 0;
    int          n_checks = 0;
    int          seed = 32'hE866;
    // undriven line shows the inverse of the pin so a stale bit cannot pass
    assign miso_w = oe_n ? ~miso : miso;
    initial forever #2 ref_clk_in = ~ref_clk_in;
    // counts clocks with the data line driven; only this process writes it
    always @(posedge ref_clk_in) begin
        if (!oe_n) begin
            oe_cnt <= oe_cnt + 1;
        end
    end
    param_table_reader DUT (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sck_in(sck),
        .cs_n_in(cs_n), .mosi_in(mosi), .uid_in(uid), .miso_out(miso), .miso_oe_n_out(oe_n));
    spi_host_model host (.ref_clk_in(ref_clk_in), .miso_in(miso_w), .sck_out(sck),
        .cs_n_out(cs_n), .mosi_out(mosi));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // trailing bits beyond whole bytes abort the frame mid-byte
    task automatic run(input logic [7:0] cmd, input logic [23:0] a, input int nb, input int xb);
        exp_q = {};
        for (int k = 0; k < nb; k++) exp_q.push_back(tbl[(a[7:0] + k) % 256]);
        host.frame(cmd, a, nb * 8 + xb);
        foreach (exp_q[i]) begin
            check(host.rx_q[i], 8'(exp_q[i]));
        end
        $display("test done at %0t addr %h bytes %0d", $time, a, nb);
    endtask : run
    initial begin
        uid = {$random(seed), $random(seed)};
        foreach (tbl[i]) tbl[i] = 8'hFF;
        for (int i = 0; i < 36; i++) tbl[128+i] = ROW[287-8*i -: 8];
        for (int i = 0; i < 8; i++) tbl[248+i] = uid[8*i +: 8];
        repeat (10) @(negedge ref_clk_in);
        nrst_in = 1'b1;
        r = $random(seed);
        run(RD_TABLE_CMD, {r[23:8], 8'h00}, 257, 0);
        run(RD_TABLE_CMD, 24'h0000F6, 6, 3);
        for (int n = 0; n < 12; n++) begin
            r = $random(seed);
            host.half_cyc = 3 + r[25:24];
            run(RD_TABLE_CMD, r[23:0], 1 + r[28:26], r[31:29]);
        end
        oe_base = oe_cnt;
        run(~RD_TABLE_CMD, 24'h000088, 0, 24);
        check({7'h00, oe_cnt != oe_base}, 8'h00);
        @(negedge ref_clk_in);
        nrst_in = 1'b0;
        repeat (3) @(negedge ref_clk_in);
        nrst_in = 1'b1;
        run(RD_TABLE_CMD, 24'h00009C, 8, 0);
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge ref_clk_in);
        num_errors++;
        $display("FAIL %0t run did not complete", $time);
        finish_test();
    end
endmodule : serial_flash_parameter_table_bench
